// ==== common/dcf_pkg.sv ====
// Constants, types and reset values for the dual-clock fifo block.
// Assumes one clock: write and read ports run on coincident edges.
package dcf_pkg;
  localparam int DATA_W = 18;
  localparam int ADDR_W = 8;
  localparam int CNT_W  = 9;
  localparam int OFS_W  = 12;
  localparam int DEPTH  = 256;
  localparam logic [12:0] DEPTH_C     = 13'h0100;
  localparam logic [12:0] HALF_ABOVE  = 13'h0081;
  localparam logic [OFS_W-1:0] AE_OFS_RST = 12'h01f;
  localparam logic [OFS_W-1:0] AF_OFS_RST = 12'h01f;
  localparam logic [DATA_W-OFS_W-1:0] OFS_PAD = 6'h00;

  // Offset register pointer, one per port direction
  typedef enum logic {
    DCF_OFS_EMPTY = 1'b0,
    DCF_OFS_FULL  = 1'b1
  } dcf_ofs_sel_t;

  // Status flags, all active low
  typedef struct packed {
    logic full_n;
    logic empty_n;
    logic almost_full_n;
    logic almost_empty_n;
    logic half_full_n;
  } dcf_flags_t;

  localparam dcf_flags_t FLAGS_RST = '{full_n: 1'b1, empty_n: 1'b0, almost_full_n: 1'b1,
                                       almost_empty_n: 1'b0, half_full_n: 1'b1};
endpackage

// ==== rtl/dcf_fifo.sv ====
// Fifo core: 256 x 18 flip-flop store, status flags, two offset registers.
// Assumes write and read clocks are tied to mclk; inputs synchronous to it.
module dcf_fifo (
  input  wire logic                        mclk,
  input  wire logic                        arst_n,
  input  wire logic [dcf_pkg::DATA_W-1:0]  data_in,
  input  wire logic                        write_enable_n,
  input  wire logic                        read_enable_n,
  input  wire logic                        offset_load_n,
  input  wire logic                        output_drive_n,
  input  wire logic                        first_in_chain_n,
  input  wire logic                        write_chain_in_n,
  input  wire logic                        read_chain_in_n,
  output logic      [dcf_pkg::DATA_W-1:0]  data_out,
  output logic                             data_out_oe_n,
  output dcf_pkg::dcf_flags_t              flags
);

  logic [dcf_pkg::DATA_W-1:0] mem_q [dcf_pkg::DEPTH];
  logic [dcf_pkg::ADDR_W-1:0] wr_ptr_q, wr_ptr_d;
  logic [dcf_pkg::ADDR_W-1:0] rd_ptr_q, rd_ptr_d;
  logic [dcf_pkg::CNT_W-1:0]  count_q, count_d;
  logic [dcf_pkg::DATA_W-1:0] dout_q, dout_d;
  logic [dcf_pkg::OFS_W-1:0]  ae_ofs_q, ae_ofs_d;
  logic [dcf_pkg::OFS_W-1:0]  af_ofs_q, af_ofs_d;
  dcf_pkg::dcf_ofs_sel_t      wr_sel_q, wr_sel_d;
  dcf_pkg::dcf_ofs_sel_t      rd_sel_q, rd_sel_d;
  dcf_pkg::dcf_flags_t        flags_q, flags_d;
  logic                       wr_fire, rd_fire, wr_ofs, rd_ofs, single_mode;

  // True when a + b reaches the limit; wide so large offsets cannot wrap
  function automatic logic reaches(input logic [12:0] a, input logic [12:0] b,
                                   input logic [12:0] limit);
    reaches = (a + b) >= limit;
  endfunction

  // Port decode; the flags gate the data ports, the load pin picks offsets
  always_comb begin
    wr_fire = !write_enable_n && offset_load_n && flags_q.full_n;
    rd_fire = !read_enable_n && offset_load_n && flags_q.empty_n;
    wr_ofs  = !write_enable_n && !offset_load_n;
    rd_ofs  = !read_enable_n && !offset_load_n;
    single_mode = !write_chain_in_n && !read_chain_in_n;
  end

  // Storage write; no reset needed since empty words are never shown
  always_ff @(posedge mclk) begin
    if (wr_fire) begin
      mem_q[wr_ptr_q] <= data_in;
    end
  end

  // Pointers, fill count and flags; flags follow the count of the next state
  always_comb begin
    wr_ptr_d = wr_ptr_q + dcf_pkg::ADDR_W'(wr_fire);
    rd_ptr_d = rd_ptr_q + dcf_pkg::ADDR_W'(rd_fire);
    count_d  = count_q + dcf_pkg::CNT_W'(wr_fire) - dcf_pkg::CNT_W'(rd_fire);
    flags_d.full_n  = !(count_d == dcf_pkg::CNT_W'(dcf_pkg::DEPTH));
    flags_d.empty_n = (count_d != '0);
    flags_d.almost_full_n =
      !reaches({4'h0, count_d}, {1'b0, af_ofs_q}, dcf_pkg::DEPTH_C);
    flags_d.almost_empty_n =
      reaches({4'h0, count_d}, 13'h0000, {1'b0, ae_ofs_q} + 13'h0001);
    flags_d.half_full_n =
      !reaches({4'h0, count_d}, 13'h0000, dcf_pkg::HALF_ABOVE);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      flags_q  <= dcf_pkg::FLAGS_RST;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q  <= count_d;
      flags_q  <= flags_d;
    end
  end

  // Offset registers and their two independent pointers
  always_comb begin
    ae_ofs_d = ae_ofs_q;
    af_ofs_d = af_ofs_q;
    wr_sel_d = wr_sel_q;
    rd_sel_d = rd_sel_q;
    if (wr_ofs) begin
      case (wr_sel_q)
        dcf_pkg::DCF_OFS_EMPTY: begin
          ae_ofs_d = data_in[dcf_pkg::OFS_W-1:0];
          wr_sel_d = dcf_pkg::DCF_OFS_FULL;
        end
        dcf_pkg::DCF_OFS_FULL: begin
          af_ofs_d = data_in[dcf_pkg::OFS_W-1:0];
          wr_sel_d = dcf_pkg::DCF_OFS_EMPTY;
        end
        default: begin
          wr_sel_d = dcf_pkg::DCF_OFS_EMPTY;
        end
      endcase
    end
    if (rd_ofs) begin
      rd_sel_d = (rd_sel_q == dcf_pkg::DCF_OFS_EMPTY) ? dcf_pkg::DCF_OFS_FULL
                                                      : dcf_pkg::DCF_OFS_EMPTY;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ae_ofs_q <= dcf_pkg::AE_OFS_RST;
      af_ofs_q <= dcf_pkg::AF_OFS_RST;
      wr_sel_q <= dcf_pkg::DCF_OFS_EMPTY;
      rd_sel_q <= dcf_pkg::DCF_OFS_EMPTY;
    end else begin
      ae_ofs_q <= ae_ofs_d;
      af_ofs_q <= af_ofs_d;
      wr_sel_q <= wr_sel_d;
      rd_sel_q <= rd_sel_d;
    end
  end

  // Output register: a word only on request, so no fall-through
  always_comb begin
    dout_d = dout_q;
    if (rd_fire) begin
      dout_d = mem_q[rd_ptr_q];
    end else if (rd_ofs) begin
      dout_d = (rd_sel_q == dcf_pkg::DCF_OFS_EMPTY) ? {dcf_pkg::OFS_PAD, ae_ofs_q}
                                                    : {dcf_pkg::OFS_PAD, af_ofs_q};
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dout_q <= '0;
    end else begin
      dout_q <= dout_d;
    end
  end

  // Pins; the half-full output only means anything in single-device mode
  always_comb begin
    data_out      = dout_q;
    data_out_oe_n = output_drive_n;
    flags         = flags_q;
    flags.half_full_n = flags_q.half_full_n || !single_mode;
  end

  // first_in_chain_n only matters for daisy chaining, which is not built
  logic unused_chain;
  assign unused_chain = first_in_chain_n;

  // Shadow fill level rebuilt from the pins alone, kept apart from count_q
  // so the flag checks below do not lean on the counter they judge
  logic [dcf_pkg::CNT_W-1:0] shadow_lvl_q, shadow_lvl_d;
  logic                      shadow_wr, shadow_rd;

  // Next shadow level; full and empty gating redone from the level itself
  always_comb begin
    shadow_wr    = !write_enable_n && offset_load_n && (shadow_lvl_q != dcf_pkg::CNT_W'(dcf_pkg::DEPTH));
    shadow_rd    = !read_enable_n && offset_load_n && (shadow_lvl_q != '0);
    shadow_lvl_d = shadow_lvl_q;
    if (shadow_wr && !shadow_rd) begin
      shadow_lvl_d = shadow_lvl_q + 9'h001;
    end else if (shadow_rd && !shadow_wr) begin
      shadow_lvl_d = shadow_lvl_q - 9'h001;
    end
  end

  // Shadow register; only the checks read it, so it costs nothing in use
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      shadow_lvl_q <= '0;
    end else begin
      shadow_lvl_q <= shadow_lvl_d;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_write_stores_word: assert property (wr_fire |=> mem_q[$past(wr_ptr_q)] == $past(data_in))
    else $error("write did not store the input word");
  a_full_blocks_wr: assert property (!flags_q.full_n |=> wr_ptr_q == $past(wr_ptr_q))
    else $error("write pointer moved while full");
  a_full_at_depth: assert property ((count_q == 9'h100) == !flags_q.full_n)
    else $error("full flag disagrees with fill count");
  a_full_release: assert property (!flags_q.full_n && rd_fire && write_enable_n |=> flags_q.full_n)
    else $error("full flag did not release after read");
  a_read_loads_word: assert property (rd_fire |=> dout_q == $past(mem_q[rd_ptr_q]))
    else $error("read did not load the next word");
  a_idle_holds_out: assert property (read_enable_n |=> $stable(dout_q))
    else $error("output register changed without read");
  a_empty_blocks_rd: assert property (!flags_q.empty_n && offset_load_n |=> $stable(dout_q))
    else $error("output changed while empty");
  a_first_word_gap: assert property (!flags_q.empty_n && wr_fire ##1 read_enable_n [*2] |=> $stable(dout_q))
    else $error("word fell through without read");
  a_ofs_write_seq: assert property (wr_ofs && wr_sel_q == dcf_pkg::DCF_OFS_EMPTY |=>
      ae_ofs_q == $past(data_in[11:0]) && wr_sel_q == dcf_pkg::DCF_OFS_FULL)
    else $error("offset write out of sequence");
  a_ofs_noop: assert property (!offset_load_n && write_enable_n |=> $stable(wr_sel_q) && $stable(wr_ptr_q))
    else $error("load without write enable acted");
  a_ofs_keep_pos: assert property (offset_load_n |=> $stable(wr_sel_q) && $stable(rd_sel_q))
    else $error("offset pointer moved outside load");
  a_ofs_read_back: assert property (rd_ofs && rd_sel_q == dcf_pkg::DCF_OFS_FULL |=>
      dout_q == {6'h00, $past(af_ofs_q)})
    else $error("offset read back wrong");
  a_paf_at_full: assert property (!flags_q.full_n |-> !flags_q.almost_full_n)
    else $error("almost-full high while full");
  a_pae_at_empty: assert property (!flags_q.empty_n |-> !flags_q.almost_empty_n)
    else $error("almost-empty high while empty");
  a_drive_pin: assert property (data_out_oe_n == output_drive_n && data_out == dout_q)
    else $error("output drive does not follow pin");

  // State seen at the first edge after reset is let go
  a_reset_ptrs: assert property ($rose(arst_n) |-> wr_ptr_q == '0 && rd_ptr_q == '0)
    else $error("pointers not at location zero after reset");
  a_reset_flags: assert property ($rose(arst_n) |-> flags_q == dcf_pkg::FLAGS_RST)
    else $error("flags not at reset levels after reset");
  a_reset_regs: assert property ($rose(arst_n) |-> dout_q == '0 &&
      ae_ofs_q == dcf_pkg::AE_OFS_RST && af_ofs_q == dcf_pkg::AF_OFS_RST)
    else $error("output or offsets not at reset values");

  // Flag levels against the shadow fill; a fresh offset lags one edge
  a_level_tracks: assert property (count_q == shadow_lvl_q)
    else $error("fill count drifted from pin history");
  a_full_level: assert property (flags_q.full_n == (shadow_lvl_q != dcf_pkg::CNT_W'(dcf_pkg::DEPTH)))
    else $error("full flag at wrong fill level");
  a_empty_level: assert property (flags_q.empty_n == (shadow_lvl_q != '0))
    else $error("empty flag at wrong fill level");
  a_paf_level: assert property ($stable(af_ofs_q) |-> flags_q.almost_full_n ==
      (({4'h0, shadow_lvl_q} + {1'b0, af_ofs_q}) < dcf_pkg::DEPTH_C))
    else $error("almost-full flag at wrong fill level");
  a_pae_level: assert property ($stable(ae_ofs_q) |-> flags_q.almost_empty_n ==
      ({4'h0, shadow_lvl_q} > {1'b0, ae_ofs_q}))
    else $error("almost-empty flag at wrong fill level");
  a_half_level: assert property (flags_q.half_full_n ==
      ({4'h0, shadow_lvl_q} < dcf_pkg::HALF_ABOVE))
    else $error("half-full flag at wrong fill level");
  a_half_forced: assert property (!single_mode |-> flags.half_full_n)
    else $error("half-full shown outside single mode");

  // Which port may move each programmable flag
  a_paf_set_wr: assert property (flags_q.almost_full_n && !wr_fire && !wr_ofs && $stable(af_ofs_q) |=>
      flags_q.almost_full_n)
    else $error("almost-full fell without a write");
  a_paf_clr_rd: assert property (!flags_q.almost_full_n && !rd_fire && !wr_ofs && $stable(af_ofs_q) |=>
      !flags_q.almost_full_n)
    else $error("almost-full rose without a read");
  a_pae_set_rd: assert property (flags_q.almost_empty_n && !rd_fire && !wr_ofs && $stable(ae_ofs_q) |=>
      flags_q.almost_empty_n)
    else $error("almost-empty fell without a read");
  a_pae_clr_wr: assert property (!flags_q.almost_empty_n && !wr_fire && !wr_ofs && $stable(ae_ofs_q) |=>
      !flags_q.almost_empty_n)
    else $error("almost-empty rose without a write");

  // Pointer and flag behaviour around the data ports
  a_empty_release: assert property (!flags_q.empty_n && wr_fire |=> flags_q.empty_n)
    else $error("empty flag stayed low after a write");
  a_no_write_idle: assert property (write_enable_n |=> $stable(wr_ptr_q))
    else $error("write pointer moved with write disabled");
  a_no_read_idle: assert property (read_enable_n |=> $stable(rd_ptr_q))
    else $error("read pointer moved with read disabled");
  a_empty_no_read: assert property (!flags_q.empty_n |=> $stable(rd_ptr_q))
    else $error("read pointer moved while empty");
  a_load_holds_ptrs: assert property (!offset_load_n |=> $stable(wr_ptr_q) && $stable(rd_ptr_q))
    else $error("fifo pointers moved during offset load");

  // Offset registers: second slot, other read slot, independent pointers
  a_ofs_write_full: assert property (wr_ofs && wr_sel_q == dcf_pkg::DCF_OFS_FULL |=>
      af_ofs_q == $past(data_in[11:0]) && wr_sel_q == dcf_pkg::DCF_OFS_EMPTY)
    else $error("almost-full offset write out of sequence");
  a_ofs_read_empty: assert property (rd_ofs && rd_sel_q == dcf_pkg::DCF_OFS_EMPTY |=>
      dout_q == {6'h00, $past(ae_ofs_q)} && rd_sel_q == dcf_pkg::DCF_OFS_FULL)
    else $error("almost-empty offset read back wrong");
  a_ofs_rd_indep: assert property (rd_ofs && !wr_ofs |=> $stable(wr_sel_q))
    else $error("offset read moved the write pointer");

  c_fill_full: cover property (!flags_q.full_n);
  c_drain_empty: cover property (rd_fire && count_q == 9'h001);
  c_ofs_both: cover property (wr_ofs ##1 wr_ofs);
  c_paf_low: cover property ($fell(flags_q.almost_full_n));
  c_half_low: cover property ($fell(flags.half_full_n));

endmodule

// ==== tb/dcf_host_model.sv ====
// Host model: writer and reader logic on the fifo controls.
// Assumes calls start just after a rising mclk edge.
module dcf_host_model (
  input  wire logic        mclk,
  output logic      [17:0] data_in,
  output logic             write_enable_n,
  output logic             read_enable_n,
  output logic             offset_load_n,
  output logic             output_drive_n,
  output logic             first_in_chain_n,
  output logic             write_chain_in_n,
  output logic             read_chain_in_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle, single device wiring
  initial begin
    {write_enable_n, read_enable_n, offset_load_n} = 3'h7;
    data_in = 18'h0_0000;
    pins(1'h0, 1'h0);
  end
  // A high chain input leaves single mode
  task automatic pins(input logic oe_n, input logic chain_n);
    output_drive_n   = oe_n;
    first_in_chain_n = 1'h0;
    write_chain_in_n = chain_n;
    read_chain_in_n  = 1'h0;
  endtask
  // One period of requests; an idle bus shows the inverse
  task automatic step(input logic w, input logic r, input logic l, input logic [17:0] d);
    write_enable_n = w;
    read_enable_n  = r;
    offset_load_n  = l;
    data_in        = w ? ~data_in : d;
    @(posedge mclk);
    #1;
  endtask
endmodule

// ==== tb/dual_clock_fifo_programmable_flags_tb_top.sv ====
// Bench: offset load, fill, overflow, drain, flag checks.
// Assumes the host model drives every fifo input but clock and reset.
module dual_clock_fifo_programmable_flags_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                mclk;
  logic                arst_n;
  logic [17:0]         din;
  logic [17:0]         dout;
  logic                wen_n, ren_n, ld_n, oe_n, fl_n, wci_n, rci_n, doe_n;
  dcf_pkg::dcf_flags_t flags;
  int                  n_mismatch, checks, cnt, i;

  dcf_host_model u_dcf_host_model (.mclk(mclk), .data_in(din), .write_enable_n(wen_n),
    .read_enable_n(ren_n), .offset_load_n(ld_n), .output_drive_n(oe_n),
    .first_in_chain_n(fl_n), .write_chain_in_n(wci_n), .read_chain_in_n(rci_n));
  dcf_fifo u_dcf_fifo (.mclk(mclk), .arst_n(arst_n), .data_in(din), .write_enable_n(wen_n),
    .read_enable_n(ren_n), .offset_load_n(ld_n), .output_drive_n(oe_n),
    .first_in_chain_n(fl_n), .write_chain_in_n(wci_n), .read_chain_in_n(rci_n),
    .data_out(dout), .data_out_oe_n(doe_n), .flags(flags));

  // 50 ns clock
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  // Distinct word per index
  function automatic logic [17:0] wd(input int k);
    return 18'h2_a500 ^ 18'(k);
  endfunction
  // Flags for count c with n=4, m=8
  function automatic dcf_pkg::dcf_flags_t ef(input int c);
    return '{full_n: c != 256, empty_n: c != 0, almost_full_n: c + 8 < 256,
             almost_empty_n: c > 4, half_full_n: c < 129};
  endfunction
  task automatic cmp_d(input logic [17:0] e, input logic [17:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected data at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic cmp_f(input dcf_pkg::dcf_flags_t e, input dcf_pkg::dcf_flags_t g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected flags at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic st(input logic w, input logic r, input logic l, input logic [17:0] d);
    u_dcf_host_model.step(w, r, l, d);
  endtask
  task automatic give_verdict;
    $display("mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Whole run is about 540 cycles
  initial begin
    #100_000;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    arst_n = 1'h0;
    n_mismatch = 0;
    checks = 0;
    repeat (12) @(posedge mclk);
    #1;
    cmp_f(dcf_pkg::FLAGS_RST, flags);
    cmp_d(18'h0_0000, dout);
    arst_n = 1'h1;
    // Defaults read back, almost-empty first
    st(1'h1, 1'h0, 1'h0, 18'h0_0000);
    cmp_d({dcf_pkg::OFS_PAD, dcf_pkg::AE_OFS_RST}, dout);
    st(1'h1, 1'h0, 1'h0, 18'h0_0000);
    cmp_d({dcf_pkg::OFS_PAD, dcf_pkg::AF_OFS_RST}, dout);
    // n=5, idle load edge, resume, m=8, wrap to n=4
    st(1'h0, 1'h1, 1'h0, 18'h0_0005);
    st(1'h1, 1'h1, 1'h0, 18'h0_0000);
    st(1'h1, 1'h1, 1'h1, 18'h0_0000);
    st(1'h0, 1'h1, 1'h0, 18'h0_0008);
    st(1'h0, 1'h1, 1'h0, 18'h0_0004);
    st(1'h1, 1'h0, 1'h0, 18'h0_0000);
    cmp_d(18'h0_0004, dout);
    st(1'h1, 1'h0, 1'h0, 18'h0_0000);
    cmp_d(18'h0_0008, dout);
    cmp_f(ef(0), flags);
    // Read while empty is ignored
    st(1'h1, 1'h0, 1'h1, 18'h0_0000);
    cmp_d(18'h0_0008, dout);
    // Fill to full, one more write dropped
    for (i = 0; i < 257; i++) begin
      st(1'h0, 1'h1, 1'h1, wd(i));
      cnt = (i < 256) ? i + 1 : 256;
      cmp_f(ef(cnt), flags);
    end
    cmp_d(18'h0_0008, dout);
    u_dcf_host_model.pins(1'h1, 1'h1);
    st(1'h1, 1'h1, 1'h1, 18'h0_0000);
    cmp_f(ef(256) | 5'h01, flags);
    cmp_d(18'h0_0001, {17'h0_0000, doe_n});
    u_dcf_host_model.pins(1'h0, 1'h0);
    st(1'h1, 1'h1, 1'h1, 18'h0_0000);
    cmp_d(18'h0_0000, {17'h0_0000, doe_n});
    // Drain past empty
    for (i = 0; i < 257; i++) begin
      st(1'h1, 1'h0, 1'h1, 18'h0_0000);
      cnt = (i < 256) ? 255 - i : 0;
      cmp_d(wd((i < 256) ? i : 255), dout);
      cmp_f(ef(cnt), flags);
    end
    // Write, then read and write together
    st(1'h0, 1'h1, 1'h1, wd(7));
    st(1'h0, 1'h0, 1'h1, wd(8));
    cmp_d(wd(7), dout);
    cmp_f(ef(1), flags);
    st(1'h1, 1'h1, 1'h1, 18'h0_0000);
    give_verdict;
  end
endmodule
